// ==== bench/jtp_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// Probe model: owns the test clock, which rests low between frames
module jtp_host (
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe
);
  logic tdo_seen = 1'b0;
  logic oe_seen  = 1'b0;
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // One 125 ns test clock; TDO taken at the rise
  task automatic pulse(input logic tms, input logic tdi);
    o_tms <= tms;
    o_tdi <= tdi;
    #62.5 o_tck <= 1'b1;
    oe_seen = i_tdo_oe;
    // Released line reads as the inverse of the last bit
    tdo_seen = i_tdo_oe ? i_tdo : ~tdo_seen;
    #62.5 o_tck <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_jtp_tap.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_jtp_tap;
  import jtp_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe, o_extest, o_dbg_req;
  logic        o_dbg_offset, o_dbg_write, q;
  logic        i_dbg_done = 1'b0;
  logic        i_dbg_err = 1'b0;
  logic        i_core_halted = 1'b0;
  logic        prev_err = 1'b0;
  logic [15:0] i_bsr_pins = 16'h0000;
  logic [15:0] o_bsr_pins;
  logic [1:0]  o_dbg_op, o_dbg_size;
  logic [31:0] o_dbg_addr;
  logic [31:0] i_dbg_rdata = 32'h0000_0000;
  logic [3:0]  o_state;
  logic [47:0] din, dout, cmd;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          busy_cnt = 0;
  int          seed = 71282;
  jtp_state_e  exp_st = JTP_TLR;
  always #4 i_clk = ~i_clk;
  jtp_tap #(.BSR_W(JTP_BSR_W)) jtp_tap_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_tck(i_tck),
    .i_tms(i_tms), .i_tdi(i_tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_bsr_pins(i_bsr_pins),
    .o_bsr_pins(o_bsr_pins), .o_extest(o_extest), .o_dbg_req(o_dbg_req), .o_dbg_op(o_dbg_op),
    .o_dbg_size(o_dbg_size), .o_dbg_offset(o_dbg_offset), .o_dbg_write(o_dbg_write),
    .o_dbg_addr(o_dbg_addr), .i_dbg_done(i_dbg_done), .i_dbg_err(i_dbg_err),
    .i_dbg_rdata(i_dbg_rdata), .i_core_halted(i_core_halted), .o_state(o_state));
  jtp_host jtp_host_inst (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .i_tdo(o_tdo),
    .i_tdo_oe(o_tdo_oe));
  ////////////////////////////////////////////////////////////////////////////
  // Slow core: answers 40 cycles after a request, long enough to observe it
  always @(posedge i_clk) begin
    busy_cnt <= (o_dbg_req === 1'b1) ? busy_cnt + 1 : 0;
    i_dbg_done <= (busy_cnt == 40);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end
  function automatic jtp_state_e nxt(jtp_state_e s, logic m);
    case (s)
      JTP_TLR:                         nxt = m ? JTP_TLR : JTP_RTI;
      JTP_RTI, JTP_UPD_DR, JTP_UPD_IR: nxt = m ? JTP_SEL_DR : JTP_RTI;
      JTP_SEL_DR:                      nxt = m ? JTP_SEL_IR : JTP_CAP_DR;
      JTP_SEL_IR:                      nxt = m ? JTP_TLR : JTP_CAP_IR;
      JTP_CAP_DR, JTP_SH_DR:           nxt = m ? JTP_EX1_DR : JTP_SH_DR;
      JTP_EX1_DR, JTP_EX2_IR:          nxt = m ? (s == JTP_EX1_DR ? JTP_UPD_DR : JTP_UPD_IR) :
                                             (s == JTP_EX1_DR ? JTP_PAU_DR : JTP_SH_IR);
      JTP_PAU_DR:                      nxt = m ? JTP_EX2_DR : JTP_PAU_DR;
      JTP_EX2_DR:                      nxt = m ? JTP_UPD_DR : JTP_SH_DR;
      JTP_CAP_IR, JTP_SH_IR:           nxt = m ? JTP_EX1_IR : JTP_SH_IR;
      JTP_EX1_IR:                      nxt = m ? JTP_UPD_IR : JTP_PAU_IR;
      default:                         nxt = m ? JTP_EX2_IR : JTP_PAU_IR;
    endcase
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bit_io(input logic m, input logic d);
    jtp_host_inst.pulse(m, d);
    q = jtp_host_inst.tdo_seen;
    chk(jtp_host_inst.oe_seen, exp_st inside {JTP_SH_DR, JTP_SH_IR});
    exp_st = nxt(exp_st, m);
    chk(o_state, exp_st);
  endtask
  task automatic scan(input logic ir, input int n, input logic [47:0] d);
    bit_io(1'b0, 1'b0);
    bit_io(1'b1, 1'b0);
    if (ir) bit_io(1'b1, 1'b0);
    bit_io(1'b0, 1'b0);
    bit_io(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, d[i]);
      dout[i] = q;
    end
    bit_io(1'b1, 1'b0);
    bit_io(1'b0, 1'b0);
  endtask
  task automatic load_ir(input logic [3:0] op);
    scan(1'b1, 4, {44'h0, op});
    chk(dout[3:0], 4'h1);
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    for (int k = 0; k < 4; k++) begin
      repeat (9) bit_io(1'($random(seed)), 1'($random(seed)));
      repeat (5) bit_io(1'b1, 1'b0);
      chk(o_state, JTP_TLR);
    end
    load_ir(JTP_OP_BYPASS);
    din = 48'($random(seed));
    scan(1'b0, 8, din);
    chk(dout[7:0], {din[6:0], 1'b0});
    load_ir(JTP_OP_SAMPLE);
    @(posedge i_clk);
    i_bsr_pins <= 16'($random(seed));
    din = 48'($random(seed));
    scan(1'b0, 16, din);
    chk(dout[15:0], i_bsr_pins);
    chk({o_extest, o_bsr_pins}, {1'b0, din[15:0]});
    load_ir(JTP_OP_EXTEST);
    chk(o_extest, 1'b1);
    load_ir(JTP_OP_DBGCMD);
    for (int i = 0; i < 6; i++) begin
      @(posedge i_clk);
      i_dbg_rdata <= $random(seed);
      i_core_halted <= i[0];
      i_dbg_err <= (i == 2);
      cmd = {i[1:0], i[0], 1'($random(seed)), 2'(i + 1), 10'h000, 32'($random(seed))};
      @(posedge i_clk);
      scan(1'b0, 48, cmd);
      chk(dout[34:0], {i_core_halted, prev_err, 1'b0, i_dbg_rdata});
      chk(o_dbg_req, 1'b1);
      chk({o_dbg_size, o_dbg_offset, o_dbg_write, o_dbg_op, o_dbg_addr},
          {(cmd[47:46] == 2'h3) ? JTP_SZ_LONG : cmd[47:46], cmd[45:42], cmd[31:0]});
      for (int w = 0; w < 100 && o_dbg_req !== 1'b0; w++) @(posedge i_clk);
      chk(o_dbg_req, 1'b0);
      prev_err = (i == 2);
    end
    results();
  end
endmodule
`default_nettype wire

// ==== design/jtp_pkg.sv ====
package jtp_pkg;
  localparam int          JTP_IR_W       = 4;
  localparam int          JTP_BSR_W      = 16;
  localparam int          JTP_RESET_TMS  = 5;
  localparam logic [3:0]  JTP_IR_RST     = 4'hF;
  // Instruction codes
  localparam logic [3:0]  JTP_OP_EXTEST  = 4'h0;
  localparam logic [3:0]  JTP_OP_SAMPLE  = 4'h1;
  localparam logic [3:0]  JTP_OP_DBGCMD  = 4'h8;
  localparam logic [3:0]  JTP_OP_BYPASS  = 4'hF;
  // Debug command word: [47:46] size, [45] offset mode, [44] write,
  // [43:42] op, [41:32] unused, [31:0] address or data
  localparam int          JTP_DBG_W      = 48;
  localparam int          JTP_F_SIZE     = 46;
  localparam int          JTP_F_OFFSET   = 45;
  localparam int          JTP_F_WRITE    = 44;
  localparam int          JTP_F_OP       = 42;
  localparam logic [1:0]  JTP_SZ_BYTE    = 2'h0;
  localparam logic [1:0]  JTP_SZ_WORD    = 2'h1;
  localparam logic [1:0]  JTP_SZ_LONG    = 2'h2;
  localparam logic [1:0]  JTP_DOP_MEM    = 2'h0;
  localparam logic [1:0]  JTP_DOP_HALT   = 2'h1;
  localparam logic [1:0]  JTP_DOP_STEP   = 2'h2;
  localparam logic [1:0]  JTP_DOP_RUN    = 2'h3;
  typedef enum logic [3:0] {
    JTP_TLR, JTP_RTI, JTP_SEL_DR, JTP_CAP_DR, JTP_SH_DR, JTP_EX1_DR,
    JTP_PAU_DR, JTP_EX2_DR, JTP_UPD_DR, JTP_SEL_IR, JTP_CAP_IR,
    JTP_SH_IR, JTP_EX1_IR, JTP_PAU_IR, JTP_EX2_IR, JTP_UPD_IR
  } jtp_state_e;
endpackage

// ==== design/jtp_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module jtp_sync #(
  parameter int W = 3
) (
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ==== design/jtp_tap.sv ====
// Summary of operation
// - Test data out changes only on a falling test clock edge.
// - Test data out is driven only in the two shift states, else released.
// - Test data in is sampled on each rising test clock edge while shifting.
// - Five rising edges with mode select high bring the controller to reset.
// - From reset, mode select low on a rising edge moves to idle.
// - All serial activity is timed by the host-supplied test clock.
// - Debug accesses carry byte, word or long sizes, full-address or offset.
// - An invalid debug address raises an error flag but never locks the port.
// - The port can halt, step and access memory while the core is halted.
// - An instruction register, decoder, boundary register and bypass bit exist.
`timescale 1ns/100ps
`default_nettype none
module jtp_tap
  import jtp_pkg::*;
#(
  parameter int BSR_W = JTP_BSR_W
) (
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_tck,
  input  wire logic             i_tms,
  input  wire logic             i_tdi,
  output logic                  o_tdo,
  output logic                  o_tdo_oe,
  input  wire logic [BSR_W-1:0] i_bsr_pins,
  output logic      [BSR_W-1:0] o_bsr_pins,
  output logic                  o_extest,
  output logic                  o_dbg_req,
  output logic      [1:0]       o_dbg_op,
  output logic      [1:0]       o_dbg_size,
  output logic                  o_dbg_offset,
  output logic                  o_dbg_write,
  output logic      [31:0]      o_dbg_addr,
  input  wire logic             i_dbg_done,
  input  wire logic             i_dbg_err,
  input  wire logic [31:0]      i_dbg_rdata,
  input  wire logic             i_core_halted,
  output logic      [3:0]       o_state
);
  //////////////////////////////////////////////////////////////////////////
  logic [2:0] pin_sync;
  logic       tck_d_reg;
  jtp_sync #(.W(3)) u_sync (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_async ({i_tck, i_tms, i_tdi}),
    .o_sync  (pin_sync)
  );
  wire tck_s = pin_sync[2];
  wire tms_s = pin_sync[1];
  wire tdi_s = pin_sync[0];
  wire tck_rise = tck_s & ~tck_d_reg;
  wire tck_fall = ~tck_s & tck_d_reg;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) tck_d_reg <= 1'b0;
    else tck_d_reg <= tck_s;
  end
  //////////////////////////////////////////////////////////////////////////
  jtp_state_e st_reg, st_next;
  always_comb begin
    case (st_reg)
      JTP_TLR:    st_next = tms_s ? JTP_TLR : JTP_RTI;
      JTP_RTI:    st_next = tms_s ? JTP_SEL_DR : JTP_RTI;
      JTP_SEL_DR: st_next = tms_s ? JTP_SEL_IR : JTP_CAP_DR;
      JTP_CAP_DR: st_next = tms_s ? JTP_EX1_DR : JTP_SH_DR;
      JTP_SH_DR:  st_next = tms_s ? JTP_EX1_DR : JTP_SH_DR;
      JTP_EX1_DR: st_next = tms_s ? JTP_UPD_DR : JTP_PAU_DR;
      JTP_PAU_DR: st_next = tms_s ? JTP_EX2_DR : JTP_PAU_DR;
      JTP_EX2_DR: st_next = tms_s ? JTP_UPD_DR : JTP_SH_DR;
      JTP_UPD_DR: st_next = tms_s ? JTP_SEL_DR : JTP_RTI;
      JTP_SEL_IR: st_next = tms_s ? JTP_TLR : JTP_CAP_IR;
      JTP_CAP_IR: st_next = tms_s ? JTP_EX1_IR : JTP_SH_IR;
      JTP_SH_IR:  st_next = tms_s ? JTP_EX1_IR : JTP_SH_IR;
      JTP_EX1_IR: st_next = tms_s ? JTP_UPD_IR : JTP_PAU_IR;
      JTP_PAU_IR: st_next = tms_s ? JTP_EX2_IR : JTP_PAU_IR;
      JTP_EX2_IR: st_next = tms_s ? JTP_UPD_IR : JTP_SH_IR;
      JTP_UPD_IR: st_next = tms_s ? JTP_SEL_DR : JTP_RTI;
      default:    st_next = JTP_TLR;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) st_reg <= JTP_TLR;
    else if (tck_rise) st_reg <= st_next;
  end
  assign o_state = st_reg;
  //////////////////////////////////////////////////////////////////////////
  logic [JTP_IR_W-1:0]  ir_reg, ir_sh_reg;
  logic [BSR_W-1:0]     bsr_reg, bsr_upd_reg;
  logic                 byp_reg;
  logic [JTP_DBG_W-1:0] dbg_reg;
  logic                 err_reg;
  // Instruction decoder; unknown codes fall back to bypass
  wire sel_bsr = (ir_reg == JTP_OP_EXTEST) || (ir_reg == JTP_OP_SAMPLE);
  wire sel_dbg = (ir_reg == JTP_OP_DBGCMD);
  wire sh_dr   = (st_reg == JTP_SH_DR);
  wire sh_ir   = (st_reg == JTP_SH_IR);
  wire cap_dr  = (st_reg == JTP_CAP_DR);
  wire upd_dr  = (st_reg == JTP_UPD_DR);
  wire dr_lsb  = sel_bsr ? bsr_reg[0] : (sel_dbg ? dbg_reg[0] : byp_reg);
  wire sh_bit  = sh_ir ? ir_sh_reg[0] : dr_lsb;
  // Capture word: read data, then busy, error and halted flags
  wire [JTP_DBG_W-1:0] dbg_cap = {12'h000, 1'b0, i_core_halted, err_reg,
                                  o_dbg_req, i_dbg_rdata};
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ir_reg    <= JTP_IR_RST;
      ir_sh_reg <= '0;
    end else if (tck_rise) begin
      if (st_reg == JTP_TLR) ir_reg <= JTP_IR_RST;
      else if (st_reg == JTP_UPD_IR) ir_reg <= ir_sh_reg;
      if (st_reg == JTP_CAP_IR) ir_sh_reg <= JTP_IR_W'(1);
      else if (sh_ir) ir_sh_reg <= {tdi_s, ir_sh_reg[JTP_IR_W-1:1]};
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bsr_reg     <= '0;
      bsr_upd_reg <= '0;
      byp_reg     <= 1'b0;
      dbg_reg     <= '0;
    end else if (tck_rise) begin
      if (cap_dr) begin
        bsr_reg <= i_bsr_pins;
        byp_reg <= 1'b0;
        dbg_reg <= dbg_cap;
      end else if (sh_dr) begin
        if (sel_bsr) bsr_reg <= {tdi_s, bsr_reg[BSR_W-1:1]};
        else if (sel_dbg) dbg_reg <= {tdi_s, dbg_reg[JTP_DBG_W-1:1]};
        else byp_reg <= tdi_s;
      end
      if (upd_dr && sel_bsr) bsr_upd_reg <= bsr_reg;
    end
  end
  assign o_bsr_pins = bsr_upd_reg;
  assign o_extest   = (ir_reg == JTP_OP_EXTEST);
  //////////////////////////////////////////////////////////////////////////
  // Debug request: raised at Update-DR, held until the core answers.
  // A new command while busy is ignored rather than queued.
  logic       req_reg;
  logic [1:0] op_reg, size_reg;
  logic       off_reg, wr_reg;
  logic [31:0] addr_reg;
  wire        launch = tck_rise && upd_dr && sel_dbg && !req_reg;
  wire [1:0]  cmd_size = dbg_reg[JTP_F_SIZE +: 2];
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      req_reg  <= 1'b0;
      op_reg   <= JTP_DOP_MEM;
      size_reg <= JTP_SZ_BYTE;
      off_reg  <= 1'b0;
      wr_reg   <= 1'b0;
      addr_reg <= '0;
    end else if (launch) begin
      req_reg  <= 1'b1;
      size_reg <= (cmd_size == 2'h3) ? JTP_SZ_LONG : cmd_size;
      off_reg  <= dbg_reg[JTP_F_OFFSET];
      wr_reg   <= dbg_reg[JTP_F_WRITE];
      op_reg   <= dbg_reg[JTP_F_OP +: 2];
      addr_reg <= dbg_reg[31:0];
    end else if (i_dbg_done) begin
      req_reg  <= 1'b0;
    end
  end
  // Error is sticky until the next command; port stays usable
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) err_reg <= 1'b0;
    else if (req_reg && i_dbg_done) err_reg <= i_dbg_err;
    else if (launch) err_reg <= 1'b0;
  end
  assign o_dbg_req    = req_reg;
  assign o_dbg_op     = op_reg;
  assign o_dbg_size   = size_reg;
  assign o_dbg_offset = off_reg;
  assign o_dbg_write  = wr_reg;
  assign o_dbg_addr   = addr_reg;
  //////////////////////////////////////////////////////////////////////////
  // Output stage moves on falling edges only
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      o_tdo    <= sh_bit;
      o_tdo_oe <= sh_dr | sh_ir;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Saturating count of consecutive TMS highs, kept for the reset check only
  localparam logic [2:0] TMS_SAT = 3'(JTP_RESET_TMS);
  logic [2:0] tms_cnt;
  wire        tms_cnt_sat = (tms_cnt == TMS_SAT);
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) tms_cnt <= '0;
    else if (tck_rise) tms_cnt <= !tms_s ? 3'h0 : (tms_cnt_sat ? tms_cnt : tms_cnt + 3'h1);
  end
  property p_tms_reset;
    @(posedge i_clk) disable iff (!i_nrst)
      tms_cnt_sat |-> (st_reg == JTP_TLR);
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("no reset after five TMS highs");
  property p_idle;
    @(posedge i_clk) disable iff (!i_nrst)
      (tck_rise && st_reg == JTP_TLR && !tms_s) |=> (st_reg == JTP_RTI);
  endproperty
  a_idle: assert property (p_idle) else $error("reset did not go to idle");
  property p_tdo_fall;
    @(posedge i_clk) disable iff (!i_nrst)
      !tck_fall |=> $stable(o_tdo) && $stable(o_tdo_oe);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("TDO moved off falling edge");
  property p_oe;
    @(posedge i_clk) disable iff (!i_nrst)
      tck_fall |=> (o_tdo_oe == $past(sh_dr | sh_ir));
  endproperty
  a_oe: assert property (p_oe) else $error("TDO enable outside shift");
  property p_state_hold;
    @(posedge i_clk) disable iff (!i_nrst)
      !tck_rise |=> $stable(st_reg);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("state moved off rising edge");
  property p_byp;
    @(posedge i_clk) disable iff (!i_nrst)
      (tck_rise && sh_dr && !sel_bsr && !sel_dbg) |=> (byp_reg == $past(tdi_s));
  endproperty
  a_byp: assert property (p_byp) else $error("bypass did not take TDI");
  property p_err_free;
    @(posedge i_clk) disable iff (!i_nrst)
      (req_reg && i_dbg_done) |=> !req_reg;
  endproperty
  a_err_free: assert property (p_err_free) else $error("debug port stuck busy");
  property p_size;
    @(posedge i_clk) disable iff (!i_nrst)
      launch |=> (o_dbg_size != 2'h3) && o_dbg_req;
  endproperty
  a_size: assert property (p_size) else $error("bad access size");
endmodule
`default_nettype wire
